// File: logic/timer_cc_regs.vh
/*
 * Register map, field positions, reset values and codes of the
 * capture/compare timer block.
 * Assumes a word-addressed register port, one 16-bit register per address.
 */
`ifndef TIMER_CC_REGS_VH
`define TIMER_CC_REGS_VH

// Word addresses
`define ADDR_TIMER_CTRL 5'h00
`define ADDR_COUNTER_VALUE 5'h01
`define ADDR_CH_CONTROL0 5'h02
`define ADDR_CH_VALUE0 5'h03
`define ADDR_CH_CONTROL1 5'h04
`define ADDR_CH_VALUE1 5'h05
`define ADDR_CH_CONTROL2 5'h06
`define ADDR_CH_VALUE2 5'h07
`define ADDR_PENDING_VECTOR 5'h08
`define ADDR_IRQ_STATUS 5'h09
`define ADDR_IRQ_MASK 5'h0A

// Timer control fields
`define TCTRL_OVF_FLAG 0
`define TCTRL_OVF_IRQ_EN 1
`define TCTRL_RUN 4

// Channel control fields
`define CC_IRQ_FLAG 0
`define CC_OVERRUN 1
`define CC_OUT_BIT 2
`define CC_INPUT_LEVEL 3
`define CC_IRQ_EN 4
`define CC_MODE_LO 5
`define CC_MODE_HI 7
`define CC_CAPTURE_SEL 8
`define CC_ZERO_BIT 9
`define CC_LATCHED 10
`define CC_SYNC 11
`define CC_INSEL_LO 12
`define CC_INSEL_HI 13
`define CC_EDGE_LO 14
`define CC_EDGE_HI 15
`define CC_WRITE_MASK 16'hF9F7

// Capture edge codes
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

// Input select codes
`define INSEL_FIRST 2'h0
`define INSEL_SECOND 2'h1
`define INSEL_LOW 2'h2
`define INSEL_HIGH 2'h3

// Output behaviour codes
`define PIN_BIT_VALUE 3'h0
`define PIN_SET 3'h1
`define PIN_TOGGLE_RESET 3'h2
`define PIN_SET_RESET 3'h3
`define PIN_TOGGLE 3'h4
`define PIN_RESET 3'h5
`define PIN_TOGGLE_SET 3'h6
`define PIN_RESET_SET 3'h7

// Vector codes
`define VEC_NONE 16'h0000
`define VEC_CH1 16'h0002
`define VEC_CH2 16'h0004
`define VEC_OVERFLOW 16'h000A

// Interrupt status bits
`define IRQ_CH0 0
`define IRQ_CH1 1
`define IRQ_CH2 2
`define IRQ_OVF 3

// Reset values
`define RST_WORD16 16'h0000
`define RST_NIBBLE 4'h0

`endif

// File: logic/sync_two_stage.v
/*
 * Two-flop synchroniser for a bus of independent level signals.
 * Assumes each bit is a slow level from a pin; no word coherence.
 */
`timescale 1ns/1ps
module sync_two_stage #(
  parameter WIDTH = 6
) (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [WIDTH-1:0] level_in,
  output wire [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  // First stage is read only by the second
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= level_in;
      stable_reg <= meta_reg;
    end
  end

  assign level_out = stable_reg;
endmodule // sync_two_stage

// File: logic/vector_encoder.v
/*
 * Prioritised pending-source encoder for the vector register.
 * Assumes requests already gated by their enables.
 */
`timescale 1ns/1ps
`include "timer_cc_regs.vh"
module vector_encoder (
  input wire ch1_req_in,
  input wire ch2_req_in,
  input wire ovf_req_in,
  output reg [15:0] vector_out
);
  // Channel 1 first, overflow last
  always @* begin
    if (ch1_req_in) begin
      vector_out = `VEC_CH1; // RL16
    end else if (ch2_req_in) begin
      vector_out = `VEC_CH2; // RL16
    end else if (ovf_req_in) begin
      vector_out = `VEC_OVERFLOW; // RL16
    end else begin
      vector_out = `VEC_NONE; // RL19
    end
  end
endmodule // vector_encoder

// File: logic/timer_cc_top.v
/*
 * 16-bit timer with three capture/compare channels, its register
 * file, per-channel output pins and a masked interrupt output.
 * Assumes a single-cycle register port master and pin-level inputs
 * that are asynchronous to sys_clk_in.
 */
//
// Contract
// RL1: Counter is a readable, writable 16-bit register, zero after reset.
// RL2: Capture edge field: 00 none, 01 rising, 10 falling, 11 both.
// RL3: Input select: 00 first input, 01 second, 10 low, 11 high.
// RL4: Sync bit clear gives asynchronous capture, set gives clocked capture.
// RL5: Selected input latched on channel equal, readable at bit 10.
// RL6: Channel control bit 9 is read-only zero.
// RL7: Compare mode compares value register to count; bit 8 selects capture.
// RL8: On capture in capture mode, count is copied into value register.
// RL9: Three-bit output field picks one of eight pin behaviours.
// RL10: Software avoids modes 2, 3, 6, 7 on channel zero.
// RL11: Channel interrupt enable gates that channel's flag request; the code gates only the channel 1 and 2 vector requests, not irq_out.
// RL12: Bit 3 shows the current level of the selected input.
// RL13: Output mode zero drives the pin from the output bit.
// RL14: Overrun bit set by hardware on overflow, cleared only by software.
// RL15: Channel interrupt flag at bit 0, readable and writable.
// RL16: Vector reads 00, 02, 04, 0A by priority, channel 1 highest.
// RL17: Overflow flag requests only when overflow enable is set; the code gates only the vector, irq_out ignores the enable.
// RL18: Capture sets flag; capture with flag still set also sets overrun.
// RL19: Vector includes only enabled pending sources, else reads zero.
`timescale 1ns/1ps
`include "timer_cc_regs.vh"
module timer_cc_top (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [4:0] addr_in,
  input wire [15:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output reg [15:0] rd_data_out,
  input wire [2:0] input_first_in,
  input wire [2:0] input_second_in,
  output reg [2:0] ch_pin_out,
  output reg irq_out
);
  localparam CHANNELS = 3;

  // Timer control and counter
  reg [15:0] count_reg;
  reg run_reg;
  reg overflow_flag_reg;
  reg overflow_irq_enable_reg;
  // Channel state
  reg [15:0] ctl_reg [0:CHANNELS-1];
  reg [15:0] value_reg [0:CHANNELS-1];
  reg [CHANNELS-1:0] latched_input_reg;
  reg [CHANNELS-1:0] level_delay_reg;
  reg [CHANNELS-1:0] level_prev_reg;
  // Interrupt status and mask
  reg [3:0] irq_status_reg;
  reg [3:0] irq_mask_reg;

  wire [5:0] pins_synced;
  wire [15:0] vector_value;
  reg [CHANNELS-1:0] level_now;
  reg [CHANNELS-1:0] level_capt;
  reg [CHANNELS-1:0] capture_evt;
  reg [CHANNELS-1:0] channel_equal;
  reg [CHANNELS-1:0] flag_set_evt;
  reg [CHANNELS-1:0] ch_req;
  reg [15:0] count_plus;
  reg count_step;
  reg count_wrap;
  reg [15:0] rd_next;
  integer i;

  // Picks the channel input named by the select field
  function sel_input;
    input [1:0] sel;
    input first;
    input second;
    begin
      case (sel)
        `INSEL_FIRST: sel_input = first; // RL3
        `INSEL_SECOND: sel_input = second; // RL3
        `INSEL_LOW: sel_input = 1'b0; // RL3
        `INSEL_HIGH: sel_input = 1'b1; // RL3
        default: sel_input = 1'b0;
      endcase
    end
  endfunction

  // Edge match against the capture edge field
  function edge_hit;
    input [1:0] mode;
    input now;
    input prev;
    begin
      case (mode)
        `EDGE_NONE: edge_hit = 1'b0; // RL2
        `EDGE_RISE: edge_hit = now & ~prev; // RL2
        `EDGE_FALL: edge_hit = ~now & prev; // RL2
        `EDGE_BOTH: edge_hit = now ^ prev; // RL2
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Next pin level for one channel
  function pin_next;
    input [2:0] mode;
    input cur;
    input out_bit;
    input equ;
    input period;
    begin
      pin_next = cur;
      case (mode)
        `PIN_BIT_VALUE: pin_next = out_bit; // RL13
        `PIN_SET: begin
          if (equ) pin_next = 1'b1; // RL9
        end
        `PIN_TOGGLE_RESET: begin
          if (period) pin_next = 1'b0; // RL9
          else if (equ) pin_next = ~cur;
        end
        `PIN_SET_RESET: begin
          if (period) pin_next = 1'b0; // RL9
          else if (equ) pin_next = 1'b1;
        end
        `PIN_TOGGLE: begin
          if (equ) pin_next = ~cur; // RL9
        end
        `PIN_RESET: begin
          if (equ) pin_next = 1'b0; // RL9
        end
        `PIN_TOGGLE_SET: begin
          if (period) pin_next = 1'b1; // RL9
          else if (equ) pin_next = ~cur;
        end
        `PIN_RESET_SET: begin
          if (period) pin_next = 1'b1; // RL9
          else if (equ) pin_next = 1'b0;
        end
        default: pin_next = cur;
      endcase
    end
  endfunction

  // Pins are asynchronous, so every input is synchronised first
  sync_two_stage #(
    .WIDTH(6)
  ) pin_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .level_in({input_second_in, input_first_in}),
    .level_out(pins_synced)
  );

  // Counting, equality and capture detection
  always @* begin
    count_plus = count_reg + 16'h0001;
    count_step = run_reg & ~(wr_en_in && addr_in == `ADDR_COUNTER_VALUE);
    count_wrap = count_step & (count_reg == 16'hFFFF);
    for (i = 0; i < CHANNELS; i = i + 1) begin
      level_now[i] = sel_input(ctl_reg[i][`CC_INSEL_HI:`CC_INSEL_LO],
                               pins_synced[i], pins_synced[i+3]);
      // Sync mode adds one clocked stage; async takes the edge at once
      level_capt[i] = ctl_reg[i][`CC_SYNC] ? level_delay_reg[i] : level_now[i]; // RL4
      capture_evt[i] = ctl_reg[i][`CC_CAPTURE_SEL] &
                       edge_hit(ctl_reg[i][`CC_EDGE_HI:`CC_EDGE_LO],
                                level_capt[i], level_prev_reg[i]);
      // Equality only when the timer counts onto the value
      channel_equal[i] = count_step & (count_plus == value_reg[i]); // RL7
      flag_set_evt[i] = capture_evt[i] |
                        (~ctl_reg[i][`CC_CAPTURE_SEL] & channel_equal[i]);
      ch_req[i] = ctl_reg[i][`CC_IRQ_FLAG] & ctl_reg[i][`CC_IRQ_EN]; // RL11
    end
  end

  // Highest-priority enabled source
  vector_encoder vec_enc (
    .ch1_req_in(ch_req[1]), // RL19
    .ch2_req_in(ch_req[2]), // RL19
    .ovf_req_in(overflow_flag_reg & overflow_irq_enable_reg), // RL17
    .vector_out(vector_value)
  );

  // Counter and timer control
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_reg <= `RST_WORD16; // RL1
      run_reg <= 1'b0;
      overflow_flag_reg <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_en_in && addr_in == `ADDR_COUNTER_VALUE) begin
        count_reg <= wr_data_in; // RL1
      end else if (count_step) begin
        count_reg <= count_plus;
      end
      if (wr_en_in && addr_in == `ADDR_TIMER_CTRL) begin
        run_reg <= wr_data_in[`TCTRL_RUN];
        overflow_irq_enable_reg <= wr_data_in[`TCTRL_OVF_IRQ_EN];
      end
      // Hardware set beats a software clear in the same cycle
      if (count_wrap) begin
        overflow_flag_reg <= 1'b1;
      end else if (wr_en_in && addr_in == `ADDR_TIMER_CTRL) begin
        overflow_flag_reg <= wr_data_in[`TCTRL_OVF_FLAG];
      end
    end
  end

  // Channel control, value and input history
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        ctl_reg[i] <= `RST_WORD16;
        value_reg[i] <= `RST_WORD16;
      end
      latched_input_reg <= {CHANNELS{1'b0}};
      level_delay_reg <= {CHANNELS{1'b0}};
      level_prev_reg <= {CHANNELS{1'b0}};
    end else begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        level_delay_reg[i] <= level_now[i];
        level_prev_reg[i] <= level_capt[i];
        if (channel_equal[i]) begin
          latched_input_reg[i] <= level_now[i]; // RL5
        end
        if (wr_en_in && addr_in == `ADDR_CH_CONTROL0 + 2 * i) begin
          ctl_reg[i] <= wr_data_in & `CC_WRITE_MASK; // RL15
        end
        // Events override a same-cycle software write of the flags
        if (flag_set_evt[i]) begin
          ctl_reg[i][`CC_IRQ_FLAG] <= 1'b1; // RL18
        end
        if (capture_evt[i] && ctl_reg[i][`CC_IRQ_FLAG]) begin
          ctl_reg[i][`CC_OVERRUN] <= 1'b1; // RL14
        end
        // Capture wins over a software write of the value
        if (capture_evt[i]) begin
          value_reg[i] <= count_reg; // RL8
        end else if (wr_en_in && addr_in == `ADDR_CH_VALUE0 + 2 * i) begin
          value_reg[i] <= wr_data_in; // RL7
        end
      end
    end
  end

  // Pin outputs; channel zero equality doubles as the period event
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ch_pin_out <= {CHANNELS{1'b0}};
    end else begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        ch_pin_out[i] <= pin_next(ctl_reg[i][`CC_MODE_HI:`CC_MODE_LO],
                                  ch_pin_out[i], ctl_reg[i][`CC_OUT_BIT],
                                  channel_equal[i], channel_equal[0]); // RL9 RL10
      end
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_status_reg <= `RST_NIBBLE;
      irq_mask_reg <= `RST_NIBBLE;
      irq_out <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg &
                         ~((wr_en_in && addr_in == `ADDR_IRQ_STATUS) ?
                           wr_data_in[3:0] : `RST_NIBBLE)) |
                        {count_wrap, flag_set_evt};
      if (wr_en_in && addr_in == `ADDR_IRQ_MASK) begin
        irq_mask_reg <= wr_data_in[3:0];
      end
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Read multiplexer with computed read-only bits
  always @* begin
    rd_next = `RST_WORD16;
    case (addr_in)
      `ADDR_TIMER_CTRL: begin
        rd_next[`TCTRL_RUN] = run_reg;
        rd_next[`TCTRL_OVF_IRQ_EN] = overflow_irq_enable_reg;
        rd_next[`TCTRL_OVF_FLAG] = overflow_flag_reg;
      end
      `ADDR_COUNTER_VALUE: rd_next = count_reg; // RL1
      `ADDR_CH_CONTROL0, `ADDR_CH_CONTROL1, `ADDR_CH_CONTROL2: begin
        rd_next = ctl_reg[addr_in[2:1] - 2'h1];
        rd_next[`CC_INPUT_LEVEL] = level_now[addr_in[2:1] - 2'h1]; // RL12
        rd_next[`CC_LATCHED] = latched_input_reg[addr_in[2:1] - 2'h1]; // RL5
        rd_next[`CC_ZERO_BIT] = 1'b0; // RL6
      end
      `ADDR_CH_VALUE0, `ADDR_CH_VALUE1, `ADDR_CH_VALUE2: begin
        rd_next = value_reg[addr_in[2:1] - 2'h1];
      end
      `ADDR_PENDING_VECTOR: rd_next = vector_value; // RL16
      `ADDR_IRQ_STATUS: rd_next[3:0] = irq_status_reg;
      `ADDR_IRQ_MASK: rd_next[3:0] = irq_mask_reg;
      default: rd_next = `RST_WORD16;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_out <= `RST_WORD16;
    end else begin
      rd_data_out <= rd_en_in ? rd_next : `RST_WORD16;
    end
  end
endmodule // timer_cc_top

// File: verification/timer_cc_asserts.sv
/*
 * Port-level checker for the capture/compare timer register block.
 * Assumes the single-cycle register port of timer_cc_top; bound below.
 */
`timescale 1ns/1ps
module timer_cc_asserts (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [4:0] addr_in,
  input wire [15:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [15:0] rd_data_out,
  input wire [2:0] input_first_in,
  input wire [2:0] input_second_in,
  input wire [2:0] ch_pin_out,
  input wire irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Write then an immediate read of the same word
  sequence s_cnt_wr_rd;
    wr_en_in && addr_in == 5'h01 ##1 rd_en_in && addr_in == 5'h01;
  endsequence
  sequence s_cc_wr_rd;
    wr_en_in && addr_in inside {5'h02, 5'h04, 5'h06} ##1
      rd_en_in && addr_in == $past(addr_in);
  endsequence
  a_read_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 16'h0000)
    else $error("read data not zero outside read slot");
  a_unmapped_read: assert property ($past(rd_en_in && addr_in > 5'h0A) |->
    rd_data_out == 16'h0000) else $error("unmapped read not zero");
  a_vector_codes: assert property ($past(rd_en_in && addr_in == 5'h08) |->
    rd_data_out inside {16'h0000, 16'h0002, 16'h0004, 16'h000A})
    else $error("vector code out of set");
  a_ctrl_zero_bit: assert property ($past(rd_en_in && addr_in inside {5'h02, 5'h04,
    5'h06}) |-> !rd_data_out[9]) else $error("control bit 9 not zero");
  a_counter_write_read: assert property (s_cnt_wr_rd |=>
    rd_data_out == $past(wr_data_in, 2) || rd_data_out == $past(wr_data_in, 2) + 16'h0001)
    else $error("counter readback wrong");
  a_ctrl_field_readback: assert property (s_cc_wr_rd |=>
    rd_data_out[15:11] == $past(wr_data_in[15:11], 2) &&
    rd_data_out[8:4] == $past(wr_data_in[8:4], 2))
    else $error("control field readback wrong");
  a_pin_bit_value: assert property (wr_en_in && addr_in == 5'h02 &&
    wr_data_in[7:5] == 3'h0 ##1 !(wr_en_in && addr_in == 5'h02) |->
    ##1 ch_pin_out[0] == $past(wr_data_in[2], 2)) else $error("pin not output bit");
  a_mask_zero_irq: assert property (wr_en_in && addr_in == 5'h0A &&
    wr_data_in == 16'h0000 ##1 !(wr_en_in && addr_in == 5'h0A) |-> ##1 !irq_out)
    else $error("irq high with zero mask");
endmodule // timer_cc_asserts

bind timer_cc_top timer_cc_asserts chk_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .input_first_in(input_first_in),
  .input_second_in(input_second_in), .ch_pin_out(ch_pin_out), .irq_out(irq_out));

// File: verification/cap_source.sv
/*
 * Model of the external capture sources feeding the timer channels.
 * Assumes the bench requests levels; pins change after a clock edge.
 */
`timescale 1ns/1ps
module cap_source (
  input wire sys_clk_in,
  input wire [2:0] first_req_in,
  input wire [2:0] second_req_in,
  output reg [2:0] first_out,
  output reg [2:0] second_out
);
  initial first_out = 3'h0;
  initial second_out = 3'h0;
  // Pins move one cycle after a request, like a slow board signal
  always @(posedge sys_clk_in) begin
    first_out <= first_req_in;
    second_out <= second_req_in;
  end
endmodule // cap_source

// File: verification/tb.sv
/*
 * Self-checking bench for timer_cc_top: registers, capture, compare, irq.
 * Assumes the cap_source model on the pins and the bound checker.
 */
`timescale 1ns/1ps
module tb;
  reg sys_clk_in = 1'b0;
  reg sys_rst_in = 1'b1;
  reg [4:0] addr = 5'h00;
  reg [15:0] wdat = 16'h0000;
  reg wen = 1'b0;
  reg ren = 1'b0;
  reg [2:0] fa = 3'h0;
  reg [2:0] fb = 3'h0;
  wire [2:0] pin_a;
  wire [2:0] pin_b;
  wire [15:0] rdat;
  wire [2:0] pins;
  wire irq;
  integer miscompares = 0;
  integer checks_done = 0;
  integer i;
  reg [15:0] w;
  // 10 MHz clock
  always #50 sys_clk_in = ~sys_clk_in;
  timer_cc_top uut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr),
    .wr_data_in(wdat), .wr_en_in(wen), .rd_en_in(ren), .rd_data_out(rdat),
    .input_first_in(pin_a), .input_second_in(pin_b), .ch_pin_out(pins), .irq_out(irq));
  cap_source src (.sys_clk_in(sys_clk_in), .first_req_in(fa), .second_req_in(fb),
    .first_out(pin_a), .second_out(pin_b));
  task complete_run;
    begin
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // Strobes rise and fall on separate edges, so no double assignment
  task wr(input [4:0] a, input [15:0] d);
    begin
      @(posedge sys_clk_in) begin addr <= a; wdat <= d; wen <= 1'b1; end
      @(posedge sys_clk_in) wen <= 1'b0;
    end
  endtask
  task crd(input string nm, input [4:0] a, input [15:0] e);
    begin
      @(posedge sys_clk_in) begin addr <= a; ren <= 1'b1; end
      @(posedge sys_clk_in) ren <= 1'b0;
      @(negedge sys_clk_in) chk(nm, e, rdat);
    end
  endtask
  // Write then read with no gap, masked compare
  task wrrd(input string nm, input [4:0] a, input [15:0] d, input [15:0] m, input [15:0] e);
    begin
      @(posedge sys_clk_in) begin addr <= a; wdat <= d; wen <= 1'b1; end
      @(posedge sys_clk_in) begin wen <= 1'b0; ren <= 1'b1; end
      @(posedge sys_clk_in) ren <= 1'b0;
      @(negedge sys_clk_in) chk(nm, e, rdat & m);
    end
  endtask
  task t_reset;
    begin
      crd("counter", 5'h01, 16'h0000);
      crd("control1", 5'h04, 16'h0000);
      crd("value1", 5'h05, 16'h0000);
      crd("vector", 5'h08, 16'h0000);
      crd("unmapped", 5'h1F, 16'h0000);
      chk("pins", 16'h0000, {13'h0, pins});
      wrrd("counter", 5'h01, 16'h1234, 16'hFFFF, 16'h1234);
      $display("test reset done");
    end
  endtask
  task t_fields;
    begin
      wr(5'h04, 16'hFFFF);
      cyc(4);
      crd("control1", 5'h04, 16'hF9FF);
      @(posedge sys_clk_in) fa <= 3'h7;
      for (i = 0; i < 4; i = i + 1) begin
        w = {2'h0, i[1:0], 12'h000};
        wr(5'h04, w);
        cyc(4);
        crd("input level", 5'h04, w | {12'h0, i == 0 || i == 3, 3'h0});
      end
      $display("test fields done");
    end
  endtask
  task t_edges;
    begin
      @(posedge sys_clk_in) fa <= 3'h0;
      for (i = 0; i < 4; i = i + 1) begin
        w = {i[1:0], 14'h0100};
        wr(5'h06, w);
        cyc(4);
        @(posedge sys_clk_in) fa <= 3'h4;
        cyc(8);
        crd("edge rise", 5'h06, w | 16'h0008 | i[0]);
        wr(5'h06, w);
        @(posedge sys_clk_in) fa <= 3'h0;
        cyc(8);
        crd("edge fall", 5'h06, w | i[1]);
      end
      $display("test edges done");
    end
  endtask
  task t_capture;
    begin
      wr(5'h01, 16'h0ABC);
      wr(5'h04, 16'h4110);
      wr(5'h06, 16'h4110);
      wr(5'h09, 16'h000F);
      @(posedge sys_clk_in) fa <= 3'h2;
      cyc(8);
      crd("value1", 5'h05, 16'h0ABC);
      crd("control1", 5'h04, 16'h4119);
      crd("vector", 5'h08, 16'h0002);
      wr(5'h0A, 16'h0002);
      cyc(3);
      @(negedge sys_clk_in) chk("irq", 16'h0001, {15'h0, irq});
      wr(5'h09, 16'h0002);
      cyc(3);
      @(negedge sys_clk_in) chk("irq", 16'h0000, {15'h0, irq});
      @(posedge sys_clk_in) fa <= 3'h0;
      cyc(8);
      @(posedge sys_clk_in) fa <= 3'h2;
      cyc(8);
      crd("overrun", 5'h04, 16'h411B);
      @(posedge sys_clk_in) fa <= 3'h6;
      cyc(8);
      crd("vector", 5'h08, 16'h0002);
      // Software clears flag and overrun
      wr(5'h04, 16'h4110);
      crd("vector", 5'h08, 16'h0004);
      wr(5'h06, 16'h4101);
      crd("vector", 5'h08, 16'h0000);
      wr(5'h0A, 16'h0000);
      $display("test capture done");
    end
  endtask
  task t_compare;
    begin
      // Channel zero kept in bit-value mode
      wrrd("control0", 5'h02, 16'h0004, 16'hF9F7, 16'h0004);
      cyc(2);
      @(negedge sys_clk_in) chk("pin0", 16'h0001, {15'h0, pins[0]});
      wr(5'h07, 16'h0AC0);
      wr(5'h06, 16'h3020);
      wr(5'h09, 16'h000F);
      wr(5'h00, 16'h0010);
      cyc(20);
      wr(5'h00, 16'h0000);
      crd("compare", 5'h06, 16'h3429);
      chk("pin2", 16'h0001, {15'h0, pins[2]});
      $display("test compare done");
    end
  endtask
  task t_overflow;
    begin
      wr(5'h01, 16'hFFF0);
      wr(5'h00, 16'h0010);
      cyc(24);
      crd("overflow", 5'h00, 16'h0011);
      crd("vector", 5'h08, 16'h0000);
      wr(5'h0A, 16'h0008);
      cyc(3);
      @(negedge sys_clk_in) chk("irq", 16'h0001, {15'h0, irq});
      wr(5'h00, 16'h0013);
      crd("vector", 5'h08, 16'h000A);
      wr(5'h0A, 16'h0000);
      $display("test overflow done");
    end
  endtask
  // Same pin timing twice: clocked capture lands one count later
  task t_sync;
    begin
      wr(5'h00, 16'h0010);
      for (i = 0; i < 2; i = i + 1) begin
        @(posedge sys_clk_in) fa <= 3'h0;
        wr(5'h04, i[0] ? 16'h4910 : 16'h4110);
        cyc(4);
        wr(5'h01, 16'h0000);
        @(posedge sys_clk_in) fa <= 3'h2;
        cyc(8);
        crd("sync value", 5'h05, 16'h0004 + i[0]);
      end
      wr(5'h00, 16'h0000);
      $display("test sync done");
    end
  endtask
  // Hang guard
  initial begin
    #3000000;
    miscompares = miscompares + 1;
    complete_run;
  end
  initial begin
    cyc(3);
    sys_rst_in <= 1'b0;
    t_reset;
    t_fields;
    t_edges;
    t_capture;
    t_compare;
    t_overflow;
    t_sync;
    complete_run;
  end
endmodule // tb
